// File: core/fwec_defines.svh
/*
 * Constants of the flash write/erase controller: register offsets, field
 * positions, reset values and timing counts.
 * Assumes a 200 MHz system clock and a 16-bit register address.
 */
`ifndef FWEC_DEFINES_SVH
`define FWEC_DEFINES_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define FWEC_OFS_CTRL       16'h6270
`define FWEC_OFS_ADDR_LOW   16'h6271
`define FWEC_OFS_ADDR_HIGH  16'h6272
`define FWEC_OFS_WDATA      16'h6273

// ----------------------------------------------------------------------
// Control/status fields
// ----------------------------------------------------------------------
`define FWEC_BIT_BUSY       7
`define FWEC_BIT_FULL       6
`define FWEC_BIT_ABORT      5
`define FWEC_CACHE_LSB      2
`define FWEC_CACHE_MSB      3
`define FWEC_BIT_WRITE      1
`define FWEC_BIT_ERASE      0
`define FWEC_CACHE_RESET    2'h1
`define FWEC_ADDR_RESET     16'h0000
`define FWEC_PAGE_LSB       8
`define FWEC_PAGE_MSB       14

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define FWEC_CLK_MHZ        200
`define FWEC_PROG_NS        20000
`define FWEC_PROG_CYC       ((`FWEC_PROG_NS * `FWEC_CLK_MHZ) / 1000)
`define FWEC_TMO_NS         20000
`define FWEC_TMO_CYC        ((`FWEC_TMO_NS * `FWEC_CLK_MHZ) / 1000)
`define FWEC_ERASE_MS       20
`define FWEC_ERASE_CYC      (`FWEC_ERASE_MS * `FWEC_CLK_MHZ * 1000)
`define FWEC_CACHE_CHG_CYC  4'h4

// ----------------------------------------------------------------------
// Writer (DMA end) own registers
// ----------------------------------------------------------------------
`define FWEC_OFS_DMA_LEN    16'h0000
`define FWEC_OFS_DMA_CTRL   16'h0001
`define FWEC_OFS_DMA_PTR    16'h0002
`define FWEC_OFS_DMA_DATA   16'h0003
`define FWEC_DMA_DEPTH      32

`endif

// File: core/fwec_pkg.sv
/*
 * Types of the flash write/erase controller and its writer.
 * Assumes fwec_defines.svh is on the include path.
 */
`default_nettype none
`include "fwec_defines.svh"

package fwec_pkg;

  typedef enum logic [1:0] {ST_IDLE, ST_ERASE, ST_FILL, ST_PROG} fwec_state_e;

  typedef struct packed {
    fwec_state_e state;
    logic        wr_bit;
    logic        er_bit;
    logic        abort;
    logic        from_flash;
    logic [15:0] waddr;
    logic [31:0] word;
    logic [31:0] clear_bits;
    logic [1:0]  nbytes;
    logic [31:0] tmr;
    logic [1:0]  cache;
    logic [1:0]  cache_req;
    logic [3:0]  cache_cnt;
    logic        trig;
    logic        prog;
    logic        erase;
    logic [7:0]  rdata;
  } fwec_dev_s;

  typedef struct packed {
    logic [`FWEC_DMA_DEPTH-1:0][7:0] buf_mem;
    logic [5:0]                      len;
    logic [5:0]                      ptr;
    logic [5:0]                      cnt;
    logic                            armed;
    logic                            pend;
    logic                            fwd_rd;
    logic [7:0]                      rdata;
  } fwec_wrt_s;

endpackage : fwec_pkg

`default_nettype wire

// File: core/fwec_if.sv
/*
 * Link between the flash controller and its writer (DMA channel or CPU).
 * Assumes both ends run on the same clk_sys.
 */
`timescale 1ns/10ps
`default_nettype none

interface fwec_if;
  logic [15:0] addr;
  logic [7:0]  wdata;
  logic        wr;
  logic        rd;
  logic [7:0]  rdata;
  logic        dma_trig;
  logic        from_flash;
  logic        fetch_stall;

  modport dev (input addr, wdata, wr, rd, from_flash,
               output rdata, dma_trig, fetch_stall);
  modport wrt (output addr, wdata, wr, rd, from_flash,
               input rdata, dma_trig, fetch_stall);
endinterface : fwec_if

`default_nettype wire

// File: core/fwec_ctrl.sv
/*
 * Flash write/erase controller: control/status, address and write-data
 * registers, word programming sequence with DMA pacing, page erase,
 * timeout, lock abort and cache-mode change requests.
 * Assumes the flash array applies fl_prog/fl_erase commands and that the
 * writer keeps to the data pacing set by dma_trig.
 */
// The plain strobed port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
`include "fwec_defines.svh"

module fwec_ctrl
  import fwec_pkg::*;
#(
  parameter int unsigned ERASE_CYC = `FWEC_ERASE_CYC
) (
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         reset,
  // Writer side
  fwec_if.dev               bus,
  // Flash array
  input  wire logic [127:0] page_lock,
  output logic              fl_prog,
  output logic [15:0]       fl_waddr,
  output logic [31:0]       fl_clear_bits,
  output logic              fl_erase,
  output logic [6:0]        fl_page,
  // Cache
  output logic [1:0]        cache_mode
);

  localparam int unsigned PROG_CYC = `FWEC_PROG_CYC;
  localparam int unsigned TMO_CYC  = `FWEC_TMO_CYC;

  fwec_dev_s s;
  fwec_dev_s next_s;

  logic       busy;
  logic       full;
  logic       page_locked;
  logic       data_wr;
  logic       ctrl_wr;
  logic [7:0] status;

  // ----------------------------------------------------------------------
  // Status view
  // ----------------------------------------------------------------------
  assign busy        = (s.state != ST_IDLE);
  assign full        = (s.state == ST_PROG);
  assign page_locked = page_lock[s.waddr[`FWEC_PAGE_MSB:`FWEC_PAGE_LSB]];
  assign data_wr     = bus.wr && (bus.addr == `FWEC_OFS_WDATA);
  assign ctrl_wr     = bus.wr && (bus.addr == `FWEC_OFS_CTRL);

  always_comb begin
    status                                   = 8'h00;
    status[`FWEC_BIT_BUSY]                   = busy;
    status[`FWEC_BIT_FULL]                   = full;
    status[`FWEC_BIT_ABORT]                  = s.abort;
    status[`FWEC_CACHE_MSB:`FWEC_CACHE_LSB]  = s.cache;
    status[`FWEC_BIT_WRITE]                  = s.wr_bit;
    status[`FWEC_BIT_ERASE]                  = s.er_bit;
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    next_s       = s;
    next_s.trig  = 1'b0;
    next_s.prog  = 1'b0;
    next_s.erase = 1'b0;
    next_s.rdata = 8'h00;

    // Register reads, answered next cycle
    if (bus.rd) begin
      unique case (bus.addr)
        `FWEC_OFS_CTRL:      next_s.rdata = status;
        `FWEC_OFS_ADDR_LOW:  next_s.rdata = s.waddr[7:0];
        `FWEC_OFS_ADDR_HIGH: next_s.rdata = s.waddr[15:8];
        default:             next_s.rdata = 8'h00;
      endcase
    end

    // Address bytes
    if (bus.wr && bus.addr == `FWEC_OFS_ADDR_LOW) begin
      next_s.waddr[7:0] = bus.wdata;
    end
    if (bus.wr && bus.addr == `FWEC_OFS_ADDR_HIGH) begin
      next_s.waddr[15:8] = bus.wdata;
    end

    // Cache mode change request
    if (s.cache_cnt != 4'h0) begin
      next_s.cache_cnt = s.cache_cnt - 4'h1;
      if (s.cache_cnt == 4'h1) begin
        next_s.cache = s.cache_req;
      end
    end else if (ctrl_wr && bus.wdata[`FWEC_CACHE_MSB:`FWEC_CACHE_LSB] != s.cache) begin
      next_s.cache_req = bus.wdata[`FWEC_CACHE_MSB:`FWEC_CACHE_LSB];
      next_s.cache_cnt = `FWEC_CACHE_CHG_CYC;
    end

    unique case (s.state)
      ST_IDLE: begin
        // Starts only from idle; running operations ignore new starts
        if (ctrl_wr && (bus.wdata[`FWEC_BIT_WRITE] || bus.wdata[`FWEC_BIT_ERASE])) begin
          next_s.abort      = 1'b0;
          next_s.from_flash = bus.from_flash;
          next_s.wr_bit     = bus.wdata[`FWEC_BIT_WRITE];
          next_s.er_bit     = bus.wdata[`FWEC_BIT_ERASE];
          next_s.tmr        = 32'h0;
          next_s.nbytes     = 2'h0;
          if (bus.wdata[`FWEC_BIT_ERASE]) begin
            if (page_locked) begin
              next_s.abort  = 1'b1;
              next_s.wr_bit = 1'b0;
              next_s.er_bit = 1'b0;
            end else begin
              next_s.state = ST_ERASE;
              next_s.erase = 1'b1;
            end
          end else begin
            next_s.state = ST_FILL;
            next_s.trig  = 1'b1;
          end
        end
      end
      ST_ERASE: begin
        next_s.tmr = s.tmr + 32'h1;
        if (s.tmr == ERASE_CYC - 1) begin
          next_s.er_bit = 1'b0;
          next_s.tmr    = 32'h0;
          if (s.wr_bit) begin
            next_s.state = ST_FILL;
            next_s.trig  = 1'b1;
          end else begin
            next_s.state = ST_IDLE;
          end
        end
      end
      ST_FILL: begin
        next_s.tmr = s.tmr + 32'h1;
        if (data_wr) begin
          next_s.word[{s.nbytes, 3'b000} +: 8] = bus.wdata;
          next_s.nbytes = s.nbytes + 2'h1;
          if (s.nbytes == 2'h3) begin
            next_s.tmr = 32'h0;
            if (page_locked) begin
              next_s.abort  = 1'b1;
              next_s.wr_bit = 1'b0;
              next_s.state  = ST_IDLE;
            end else begin
              next_s.state      = ST_PROG;
              next_s.prog       = 1'b1;
              next_s.clear_bits = ~{bus.wdata, s.word[23:0]};
            end
          end else begin
            next_s.trig = 1'b1;
          end
        end else if (s.tmr >= TMO_CYC - 1) begin
          // Byte in the last cycle must not push the limit out of reach
          next_s.wr_bit = 1'b0;
          next_s.state  = ST_IDLE;
        end
      end
      ST_PROG: begin
        // Data port writes are dropped while the word programs
        next_s.tmr = s.tmr + 32'h1;
        if (s.tmr == PROG_CYC - 1) begin
          next_s.waddr  = s.waddr + 16'h1;
          next_s.state  = ST_FILL;
          next_s.tmr    = 32'h0;
          next_s.nbytes = 2'h0;
          next_s.trig   = 1'b1;
        end
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s            <= '0;
      s.state      <= ST_IDLE;
      s.waddr      <= `FWEC_ADDR_RESET;
      s.cache      <= `FWEC_CACHE_RESET;
      s.cache_req  <= `FWEC_CACHE_RESET;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign bus.rdata       = s.rdata;
  assign bus.dma_trig    = s.trig;
  assign bus.fetch_stall = busy && s.from_flash;
  assign fl_prog         = s.prog;
  assign fl_waddr        = s.waddr;
  assign fl_clear_bits   = s.clear_bits;
  assign fl_erase        = s.erase;
  assign fl_page         = s.waddr[`FWEC_PAGE_MSB:`FWEC_PAGE_LSB];
  assign cache_mode      = s.cache;

endmodule : fwec_ctrl

`default_nettype wire

// File: core/fwec_writer.sv
/*
 * Writer end: forwards software accesses to the controller registers and
 * runs a byte DMA channel from a local buffer to the write-data port.
 * Assumes software loads the buffer, sets length and arms before starting.
 */
`timescale 1ns/10ps
`default_nettype none
`include "fwec_defines.svh"

module fwec_writer
  import fwec_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset,
  // Software port
  input  wire logic [15:0] sw_addr,
  input  wire logic [7:0]  sw_wdata,
  input  wire logic        sw_wr,
  input  wire logic        sw_rd,
  output logic [7:0]       sw_rdata,
  input  wire logic        code_in_flash,
  output logic             cpu_stall,
  // Controller side
  fwec_if.wrt              bus
);

  fwec_wrt_s s;
  fwec_wrt_s next_s;

  logic fwd;
  logic dma_go;

  // ----------------------------------------------------------------------
  // Bus sharing
  // ----------------------------------------------------------------------
  assign fwd    = (sw_wr || sw_rd) && sw_addr >= `FWEC_OFS_CTRL && sw_addr <= `FWEC_OFS_WDATA;
  assign dma_go = s.pend && s.armed && !fwd;

  assign bus.addr       = fwd ? sw_addr : `FWEC_OFS_WDATA;
  assign bus.wdata      = fwd ? sw_wdata : s.buf_mem[s.cnt[4:0]];
  assign bus.wr         = (fwd && sw_wr) || dma_go;
  assign bus.rd         = fwd && sw_rd;
  assign bus.from_flash = code_in_flash;
  assign cpu_stall      = bus.fetch_stall;
  assign sw_rdata       = s.fwd_rd ? bus.rdata : s.rdata;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    next_s        = s;
    next_s.fwd_rd = fwd && sw_rd;
    next_s.rdata  = 8'h00;

    if (dma_go) begin
      next_s.pend = 1'b0;
      next_s.cnt  = s.cnt + 6'h1;
      if (s.cnt + 6'h1 == s.len) begin
        next_s.armed = 1'b0;
      end
    end
    if (bus.dma_trig && s.armed) begin
      next_s.pend = 1'b1;
    end

    if (sw_wr && !fwd) begin
      unique case (sw_addr)
        `FWEC_OFS_DMA_LEN:  next_s.len = {sw_wdata[5:2], 2'b00};
        `FWEC_OFS_DMA_CTRL: begin
          next_s.armed = sw_wdata[0] && s.len != 6'h0;
          next_s.cnt   = 6'h0;
          next_s.pend  = 1'b0;
        end
        `FWEC_OFS_DMA_PTR:  next_s.ptr = sw_wdata[5:0];
        `FWEC_OFS_DMA_DATA: begin
          next_s.buf_mem[s.ptr[4:0]] = sw_wdata;
          next_s.ptr                 = s.ptr + 6'h1;
        end
        default: ;
      endcase
    end
    if (sw_rd && !fwd) begin
      unique case (sw_addr)
        `FWEC_OFS_DMA_LEN:  next_s.rdata = {2'b00, s.len};
        `FWEC_OFS_DMA_CTRL: next_s.rdata = {1'b0, s.pend, s.cnt[5:0]} | {7'h00, s.armed};
        `FWEC_OFS_DMA_PTR:  next_s.rdata = {2'b00, s.ptr};
        default:            next_s.rdata = 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

endmodule : fwec_writer

`default_nettype wire

// File: bench/fwec_props.sv
/* Checker on the controller/writer link.
   Assumes one clock and a synchronous reset. */
`timescale 1ns/10ps
`default_nettype none
`include "fwec_defines.svh"
module fwec_props (
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        reset,
  // Link
  input wire logic [15:0] addr,
  input wire logic [7:0]  wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [7:0]  rdata,
  input wire logic        dma_trig,
  input wire logic        from_flash,
  input wire logic        fetch_stall
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  logic [7:0] lo;
  logic [7:0] hi;
  logic       rc;
  logic       launch;
  assign rc     = rd && addr == `FWEC_OFS_CTRL;
  assign launch = wr && addr == `FWEC_OFS_CTRL && from_flash;
  // --------
  // Address shadows
  // --------
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      lo <= 8'h00;
      hi <= 8'h00;
    end else if (wr && addr == `FWEC_OFS_ADDR_LOW) begin
      lo <= wdata;
    end else if (wr && addr == `FWEC_OFS_ADDR_HIGH) begin
      hi <= wdata;
    end
  end
  property p_trig; dma_trig |=> !dma_trig; endproperty
  property p_wd; rd && addr == `FWEC_OFS_WDATA |=> rdata == 8'h00; endproperty
  property p_idle; !rd |=> rdata == 8'h00; endproperty
  property p_lo; rd && addr == `FWEC_OFS_ADDR_LOW |=> rdata == $past(lo); endproperty
  property p_hi; rd && addr == `FWEC_OFS_ADDR_HIGH |=> rdata == $past(hi); endproperty
  property p_busy; rc |=> rdata[7] == (rdata[1] | rdata[0]); endproperty
  property p_full; rc |=> !rdata[6] || rdata[1]; endproperty
  property p_abort; rc |=> !(rdata[5] && rdata[7]); endproperty
  property p_stall; $rose(fetch_stall) |-> $past(launch); endproperty
  a_trig: assert property (p_trig) else $error("trigger longer than one cycle");
  a_wd: assert property (p_wd) else $error("data port read not zero");
  a_idle: assert property (p_idle) else $error("read data without read");
  a_lo: assert property (p_lo) else $error("address low mismatch");
  a_hi: assert property (p_hi) else $error("address high mismatch");
  a_busy: assert property (p_busy) else $error("busy flag mismatch");
  a_full: assert property (p_full) else $error("full outside write");
  a_abort: assert property (p_abort) else $error("abort while busy");
  a_stall: assert property (p_stall) else $error("stall without launch");
  c_trig: cover property (dma_trig);
  c_stall: cover property ($rose(fetch_stall));
  c_abort: cover property (rc ##1 rdata[5]);
endmodule : fwec_props
`default_nettype wire

// File: bench/testbench.sv
/* Bench: writer and controller joined by the link, driven from the
   software port. Assumes the erase count shortened to 50 cycles. */
`timescale 1ns/10ps
`default_nettype none
`include "fwec_defines.svh"
module testbench;
  import fwec_pkg::*;
  localparam int          ECYC = 50;
  localparam logic [15:0] CT   = `FWEC_OFS_CTRL;
  localparam logic [15:0] LO   = `FWEC_OFS_ADDR_LOW;
  localparam logic [15:0] HI   = `FWEC_OFS_ADDR_HIGH;
  localparam logic [15:0] WD   = `FWEC_OFS_WDATA;
  logic         clk_sys, reset, sw_wr, sw_rd, code_in_flash, cpu_stall, fl_prog, fl_erase;
  logic [15:0]  sw_addr, fl_waddr;
  logic [7:0]   sw_wdata, sw_rdata;
  logic [127:0] page_lock;
  logic [31:0]  fl_clear_bits;
  logic [6:0]   fl_page, pg;
  logic [1:0]   cache_mode;
  logic [15:0]  pa[$];
  logic [31:0]  pc[$];
  int           err_count, cmp_count, cyc, n_er, n_tr, t_er, t_tr;
  // --------
  // Design
  // --------
  fwec_if lnk();
  fwec_ctrl #(.ERASE_CYC(ECYC)) fwec_ctrl_inst (.clk_sys(clk_sys), .reset(reset),
    .bus(lnk.dev), .page_lock(page_lock), .fl_prog(fl_prog), .fl_waddr(fl_waddr),
    .fl_clear_bits(fl_clear_bits), .fl_erase(fl_erase), .fl_page(fl_page),
    .cache_mode(cache_mode));
  fwec_writer fwec_writer_inst (.clk_sys(clk_sys), .reset(reset), .sw_addr(sw_addr),
    .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata),
    .code_in_flash(code_in_flash), .cpu_stall(cpu_stall), .bus(lnk.wrt));
  fwec_props fwec_props_inst (.clk_sys(clk_sys), .reset(reset), .addr(lnk.addr),
    .wdata(lnk.wdata), .wr(lnk.wr), .rd(lnk.rd), .rdata(lnk.rdata),
    .dma_trig(lnk.dma_trig), .from_flash(lnk.from_flash), .fetch_stall(lnk.fetch_stall));
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // Flash-side and DMA trigger monitor
  always @(posedge clk_sys) begin
    cyc++;
    if (fl_prog) begin
      pa.push_back(fl_waddr);
      pc.push_back(fl_clear_bits);
    end
    if (fl_erase) begin
      n_er++;
      t_er = cyc;
      pg = fl_page;
    end
    if (lnk.dma_trig) begin
      n_tr++;
      t_tr = cyc;
    end
  end
  // --------
  // Tasks
  // --------
  task automatic wr8(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge clk_sys);
    sw_wr <= 1'b0;
  endtask : wr8
  task automatic rd8(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge clk_sys);
    sw_rd <= 1'b0;
    @(negedge clk_sys);
    d = sw_rdata;
  endtask : rd8
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic chk_reg(input logic [15:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd8(a, d);
    chk($sformatf("reg %h", a), {24'h0, e}, {24'h0, d});
  endtask : chk_reg
  task automatic wait_idle(input int n);
    logic [7:0] d;
    d = 8'h80;
    for (int i = 0; i < n && d[7] !== 1'b0; i++) rd8(CT, d);
  endtask : wait_idle
  task automatic wrap_up;
    $display("checks %0d errors %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : wrap_up
  // --------
  // Scenarios
  // --------
  task automatic t_reset;
    chk_reg(LO, 8'h00);
    chk_reg(HI, 8'h00);
    chk_reg(CT, 8'h04);
    chk_reg(WD, 8'h00);
    chk_reg(16'h6274, 8'h00);
    chk("cache", 1, cache_mode);
  endtask : t_reset
  task automatic t_cache;
    for (int m = 0; m < 4; m++) begin
      wr8(CT, 8'(m << 2));
      repeat (8) @(posedge clk_sys);
      chk_reg(CT, 8'(m << 2));
      chk("cache", m, cache_mode);
    end
    wr8(CT, 8'h08);
    wr8(CT, 8'h04);
    repeat (8) @(posedge clk_sys);
    chk_reg(CT, 8'h08);
    wr8(CT, 8'h04);
    repeat (8) @(posedge clk_sys);
  endtask : t_cache
  task automatic t_write;
    logic [7:0] b [8];
    b = '{8'h11, 8'h22, 8'h33, 8'h44, 8'hf0, 8'hff, 8'hff, 8'h7f};
    wr8(HI, 8'h02);
    wr8(LO, 8'h34);
    chk_reg(LO, 8'h34);
    chk_reg(HI, 8'h02);
    wr8(WD, 8'h00);
    wr8(`FWEC_OFS_DMA_PTR, 8'h00);
    foreach (b[i]) wr8(`FWEC_OFS_DMA_DATA, b[i]);
    wr8(`FWEC_OFS_DMA_LEN, 8'h0b);
    chk_reg(`FWEC_OFS_DMA_LEN, 8'h08);
    wr8(`FWEC_OFS_DMA_CTRL, 8'h01);
    wr8(CT, 8'h06);
    repeat (30) @(posedge clk_sys);
    chk_reg(CT, 8'hc6);
    wr8(WD, 8'h00);
    wait_idle(6500);
    chk_reg(CT, 8'h04);
    chk("words", 2, pa.size());
    chk("addr0", 16'h0234, pa[0]);
    chk("addr1", 16'h0235, pa[1]);
    chk("clear0", 32'hbbccddee, pc[0]);
    chk("clear1", 32'h8000000f, pc[1]);
    chk("trigs", 9, n_tr);
  endtask : t_write
  task automatic t_erase;
    wr8(HI, 8'h85);
    wr8(CT, 8'h05);
    chk_reg(CT, 8'h85);
    repeat (ECYC + 10) @(posedge clk_sys);
    chk_reg(CT, 8'h04);
    chk("erases", 1, n_er);
    chk("page", 5, pg);
  endtask : t_erase
  task automatic t_lock;
    @(posedge clk_sys);
    page_lock[3] <= 1'b1;
    wr8(HI, 8'h03);
    wr8(CT, 8'h05);
    repeat (4) @(posedge clk_sys);
    chk_reg(CT, 8'h24);
    chk("erases", 1, n_er);
    wr8(HI, 8'h05);
    wr8(CT, 8'h05);
    chk_reg(CT, 8'h85);
    wr8(CT, 8'h06);
    repeat (ECYC + 10) @(posedge clk_sys);
    chk_reg(CT, 8'h04);
  endtask : t_lock
  task automatic t_both;
    @(posedge clk_sys);
    code_in_flash <= 1'b1;
    wr8(CT, 8'h07);
    @(negedge clk_sys);
    chk("stall", 1, cpu_stall);
    repeat (ECYC + 4100) @(posedge clk_sys);
    chk("stall", 0, cpu_stall);
    chk("erases", 3, n_er);
    chk("order", 1, t_tr - t_er >= ECYC);
    code_in_flash <= 1'b0;
    chk_reg(CT, 8'h04);
  endtask : t_both
  // --------
  // Run
  // --------
  initial begin
    reset = 1'b1;
    sw_addr = 16'h0000;
    sw_wdata = 8'h00;
    sw_wr = 1'b0;
    sw_rd = 1'b0;
    code_in_flash = 1'b0;
    page_lock = '0;
    repeat (10) @(posedge clk_sys);
    reset <= 1'b0;
    t_reset;
    t_cache;
    t_write;
    t_erase;
    t_lock;
    t_both;
    wrap_up;
  end
  initial begin
    repeat (40000) @(posedge clk_sys);
    err_count++;
    wrap_up;
  end
endmodule : testbench
`default_nettype wire
